// file: testbench/req_source_model.sv
// Peripheral request sources feeding the priority block.
`timescale 1ns/1ns
module req_source_model
    import irq_prio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [NUM_REQ-1:0] pattern,
    output logic [NUM_REQ-1:0] irq_req
);
    // Launched on the edge like a peripheral flag; reset covers the first cycle
    always @(posedge ref_clk) begin
        irq_req <= pattern;
    end
endmodule

// file: testbench/test_irq_priority_regs.sv
// Self-checking bench for the priority-level register block.
`timescale 1ns/1ns
module test_irq_priority_regs;
    import irq_prio_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
        logic [31:0] exp;
    } row_s;
    logic ref_clk;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_REQ-1:0] req_pat;
    logic [NUM_REQ-1:0] irq_req;
    logic [NUM_REQ-1:0] arb_req;
    logic [2*NUM_REQ-1:0] arb_level;
    logic [31:0] rd;
    logic er;
    int err_total;
    int total_checks;
    row_s rows [6];

    irq_priority_regs DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_req(irq_req), .arb_req(arb_req), .arb_level(arb_level));
    req_source_model src (.ref_clk(ref_clk), .pattern(req_pat), .irq_req(irq_req));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Master releases the bus for a cycle between transfers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end
        @(posedge ref_clk);
    endtask

    function automatic logic [1:0] fld(input int k, input logic [15:0] t, s, p);
        if (k < 8) return t[(14-2*k) +: 2];
        if (k < 10) return s[(30-2*k) +: 2];
        if (k < 15) return s[(28-2*k) +: 2];
        return p[(44-2*k) +: 2];
    endfunction

    task automatic arb_check(input logic [15:0] t, s, p, input logic [NUM_REQ-1:0] q);
        logic [1:0] f;
        apb(1'b1, 8'(ADDR_TIMER), {16'h0, t}, 4'hF);
        apb(1'b1, 8'(ADDR_SERIAL), {16'h0, s}, 4'hF);
        apb(1'b1, 8'(ADDR_PWM), {16'h0, p}, 4'hF);
        req_pat <= q;
        repeat (4) @(posedge ref_clk);
        for (int k = 0; k < NUM_REQ; k++) begin
            f = fld(k, t, s & SERIAL_WR_MASK, p);
            chk({31'h0, arb_req[k]}, {31'h0, q[k] && f != 2'h0});
            chk({30'h0, arb_level[2*k +: 2]}, (q[k] && f != 2'h0) ? 32'(f - 2'h1) : 0);
        end
        $display("test arb %h %h %h done", t, s, p);
    endtask

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        req_pat = '0;
        err_total = 0;
        total_checks = 0;
        rows[0] = '{8'(ADDR_TIMER), 32'h0000FFFF, 4'h3, 32'h0000FFFF};
        rows[1] = '{8'(ADDR_SERIAL), 32'h0000FFFF, 4'h3, 32'h0000F3FF};
        rows[2] = '{8'(ADDR_PWM), 32'h0000FFFF, 4'h3, 32'h0000FFFF};
        rows[3] = '{8'(ADDR_TIMER), 32'h000000A5, 4'h1, 32'h0000FFA5};
        rows[4] = '{8'(ADDR_SERIAL), 32'h00005C00, 4'h2, 32'h000050FF};
        rows[5] = '{8'(ADDR_PWM), 32'hABCD1234, 4'hF, 32'h00001234};
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(ADDR_TIMER + 4*i), 32'h0, 4'h0);
            chk(rd, {16'h0, RESET_LEVELS});
        end
        chk({9'h0, arb_req}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, rows[i].strb);
            apb(1'b0, rows[i].addr, 32'h0, 4'h0);
            chk(rd, rows[i].exp);
            chk({31'h0, er}, 32'h0);
        end
        $display("test table done");
        arb_check(16'h1B1B, 16'h1B1B, 16'h1B1B, '1);
        arb_check(16'hE4E4, 16'hE4E4, 16'hE4E4, 23'h555555);
        arb_check(16'h36C9, 16'hC936, 16'h9C63, 23'h2AAAAA);
        apb(1'b1, 8'h28, 32'h0000FFFF, 4'hF);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 8'h10, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 8'(ADDR_PWM), 32'h0, 4'h0);
        chk(rd, 32'h00009C63);
        $display("test unmapped done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        apb(1'b0, 8'(ADDR_SERIAL), 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({9'h0, arb_req}, 32'h0);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule

// file: verilog/irq_prio_pkg.sv
// Constants for the priority-level register block.
package irq_prio_pkg;

    localparam int NUM_REQ = 23;
    localparam int FIELD_W = 2;

    // Printed offsets are word indices; byte address is four times the index
    localparam int IDX_TIMER = 7;
    localparam int IDX_SERIAL = 8;
    localparam int IDX_PWM = 9;
    localparam int ADDR_TIMER = IDX_TIMER * 4;
    localparam int ADDR_SERIAL = IDX_SERIAL * 4;
    localparam int ADDR_PWM = IDX_PWM * 4;

    localparam logic [15:0] RESET_LEVELS = 16'h0000;
    localparam logic [15:0] SERIAL_WR_MASK = 16'hF3FF;

    localparam logic [1:0] LVL_MASKED = 2'h0;
    localparam logic [1:0] LVL_0 = 2'h1;
    localparam logic [1:0] LVL_1 = 2'h2;
    localparam logic [1:0] LVL_2 = 2'h3;

    // Timer register fields
    localparam int TIMER_A_CH0_LEVEL_POS = 14;
    localparam int TIMER_B_CH3_LEVEL_POS = 12;
    localparam int TIMER_B_CH2_LEVEL_POS = 10;
    localparam int TIMER_B_CH1_LEVEL_POS = 8;
    localparam int TIMER_B_CH0_LEVEL_POS = 6;
    localparam int TIMER_C_CH3_LEVEL_POS = 4;
    localparam int TIMER_C_CH2_LEVEL_POS = 2;
    localparam int TIMER_C_CH1_LEVEL_POS = 0;

    // Serial register fields
    localparam int SERIAL0_RX_FULL_LEVEL_POS = 14;
    localparam int SERIAL0_RX_ERROR_LEVEL_POS = 12;
    localparam int SERIAL0_TX_IDLE_LEVEL_POS = 8;
    localparam int SERIAL0_TX_EMPTY_LEVEL_POS = 6;
    localparam int TIMER_A_CH3_LEVEL_POS = 4;
    localparam int TIMER_A_CH2_LEVEL_POS = 2;
    localparam int TIMER_A_CH1_LEVEL_POS = 0;

    // PWM and converter register fields
    localparam int PWM_A_FAULT_LEVEL_POS = 14;
    localparam int PWM_B_FAULT_LEVEL_POS = 12;
    localparam int PWM_A_RELOAD_LEVEL_POS = 10;
    localparam int PWM_B_RELOAD_LEVEL_POS = 8;
    localparam int CONVERTER_A_ZERO_LIMIT_LEVEL_POS = 6;
    localparam int CONVERTER_B_ZERO_CROSS_LEVEL_POS = 4;
    localparam int CONVERTER_A_DONE_LEVEL_POS = 2;
    localparam int CONVERTER_B_DONE_LEVEL_POS = 0;

    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_ACK = 1'b1
    } apb_state_e;

endpackage

// file: verilog/irq_priority_regs.sv
// Priority-level registers seven to nine with APB access and request gating.
`timescale 1ns/1ns
// Functional notes
// [R1] Field codes: masked, level 0, 1, 2
// [R2] All fields reset to masked
// [R3] Serial register bits 11-10 read zero
// [R4] Timer reg bits 15-14: timer A ch0
// [R5] Timer reg 13-12 B ch3, 11-10 B ch2
// [R6] Timer reg 9-8 B ch1, 7-6 B ch0
// [R7] Timer reg bits 5-4: timer C ch3
// [R8] Timer reg 3-2 C ch2, 1-0 C ch1
// [R9] Serial reg bits 15-14: receiver full
// [R10] Serial reg bits 13-12: receiver error
// [R11] Serial reg bits 9-8: transmitter idle
// [R12] Serial reg bits 7-6: transmitter empty
// [R13] Serial reg bits 5-4: timer A ch3
// [R14] Serial reg 3-2 A ch2, 1-0 A ch1
// [R15] PWM reg bits 15-14: PWM A fault
// [R16] PWM reg bits 13-12: PWM B fault
// [R17] PWM reg bits 11-10: PWM A reload
// [R18] PWM reg bits 9-8: PWM B reload
// [R19] PWM reg bits 7-6: converter A zero/limit
// [R20] PWM reg bits 5-4: converter B zero
// [R21] PWM reg 3-2, 1-0: converter A/B done
// [R22] Masked requests never reach arbitration
// [R23] Writes land at completing edge; reads current
module irq_priority_regs
    import irq_prio_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_REQ-1:0] irq_req,
    output logic [NUM_REQ-1:0] arb_req,
    output logic [2*NUM_REQ-1:0] arb_level
);

    typedef struct packed {
        apb_state_e st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [15:0] timer_ab_c_priority_levels;
        logic [15:0] serial_timer_a_priority_levels;
        logic [15:0] pwm_converter_priority_levels;
        logic [NUM_REQ-1:0] arb_req;
        logic [2*NUM_REQ-1:0] arb_level;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic hit_timer;
    logic hit_serial;
    logic hit_pwm;
    logic mapped;
    logic [15:0] read_val;
    logic [2*NUM_REQ-1:0] fieldv;
    logic [NUM_REQ-1:0] nz_vec;

    level_if #(.N(NUM_REQ)) lif ();

    level_gate #(.N(NUM_REQ)) u_gate (
        .lif(lif.gate)
    );

    // Only the low two byte lanes carry register bits
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [15:0] wdata,
        input logic [1:0] strb
    );
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = wdata[15:8];
        end
    endfunction

    assign hit_timer = (paddr == ADDR_W'(ADDR_TIMER));
    assign hit_serial = (paddr == ADDR_W'(ADDR_SERIAL));
    assign hit_pwm = (paddr == ADDR_W'(ADDR_PWM));
    assign mapped = hit_timer || hit_serial || hit_pwm;

    always_comb begin
        read_val = 16'h0000;
        if (hit_timer) begin
            read_val = st_r.timer_ab_c_priority_levels; // R23
        end else if (hit_serial) begin
            read_val = st_r.serial_timer_a_priority_levels & SERIAL_WR_MASK; // R3
        end else if (hit_pwm) begin
            read_val = st_r.pwm_converter_priority_levels;
        end
    end

    // Request index k uses fieldv[2k+1:2k]
    always_comb begin
        fieldv = '0;
        fieldv[2*0 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_A_CH0_LEVEL_POS +: FIELD_W]; // R4
        fieldv[2*1 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_B_CH3_LEVEL_POS +: FIELD_W]; // R5
        fieldv[2*2 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_B_CH2_LEVEL_POS +: FIELD_W]; // R5
        fieldv[2*3 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_B_CH1_LEVEL_POS +: FIELD_W]; // R6
        fieldv[2*4 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_B_CH0_LEVEL_POS +: FIELD_W]; // R6
        fieldv[2*5 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_C_CH3_LEVEL_POS +: FIELD_W]; // R7
        fieldv[2*6 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_C_CH2_LEVEL_POS +: FIELD_W]; // R8
        fieldv[2*7 +: FIELD_W] =
            st_r.timer_ab_c_priority_levels[TIMER_C_CH1_LEVEL_POS +: FIELD_W]; // R8
        fieldv[2*8 +: FIELD_W] =
            st_r.serial_timer_a_priority_levels[SERIAL0_RX_FULL_LEVEL_POS +: FIELD_W]; // R9
        fieldv[2*9 +: FIELD_W] =
            st_r.serial_timer_a_priority_levels[SERIAL0_RX_ERROR_LEVEL_POS +: FIELD_W]; // R10
        fieldv[2*10 +: FIELD_W] =
            st_r.serial_timer_a_priority_levels[SERIAL0_TX_IDLE_LEVEL_POS +: FIELD_W]; // R11
        fieldv[2*11 +: FIELD_W] =
            st_r.serial_timer_a_priority_levels[SERIAL0_TX_EMPTY_LEVEL_POS +: FIELD_W]; // R12
        fieldv[2*12 +: FIELD_W] =
            st_r.serial_timer_a_priority_levels[TIMER_A_CH3_LEVEL_POS +: FIELD_W]; // R13
        fieldv[2*13 +: FIELD_W] =
            st_r.serial_timer_a_priority_levels[TIMER_A_CH2_LEVEL_POS +: FIELD_W]; // R14
        fieldv[2*14 +: FIELD_W] =
            st_r.serial_timer_a_priority_levels[TIMER_A_CH1_LEVEL_POS +: FIELD_W]; // R14
        fieldv[2*15 +: FIELD_W] =
            st_r.pwm_converter_priority_levels[PWM_A_FAULT_LEVEL_POS +: FIELD_W]; // R15
        fieldv[2*16 +: FIELD_W] =
            st_r.pwm_converter_priority_levels[PWM_B_FAULT_LEVEL_POS +: FIELD_W]; // R16
        fieldv[2*17 +: FIELD_W] =
            st_r.pwm_converter_priority_levels[PWM_A_RELOAD_LEVEL_POS +: FIELD_W]; // R17
        fieldv[2*18 +: FIELD_W] =
            st_r.pwm_converter_priority_levels[PWM_B_RELOAD_LEVEL_POS +: FIELD_W]; // R18
        fieldv[2*19 +: FIELD_W] = st_r.pwm_converter_priority_levels[
            CONVERTER_A_ZERO_LIMIT_LEVEL_POS +: FIELD_W]; // R19
        fieldv[2*20 +: FIELD_W] = st_r.pwm_converter_priority_levels[
            CONVERTER_B_ZERO_CROSS_LEVEL_POS +: FIELD_W]; // R20
        fieldv[2*21 +: FIELD_W] =
            st_r.pwm_converter_priority_levels[CONVERTER_A_DONE_LEVEL_POS +: FIELD_W]; // R21
        fieldv[2*22 +: FIELD_W] =
            st_r.pwm_converter_priority_levels[CONVERTER_B_DONE_LEVEL_POS +: FIELD_W]; // R21
    end

    assign lif.fields = fieldv;
    assign lif.req = irq_req;

    always_comb begin
        st_nxt = st_r;
        // Registered gate output costs one cycle but keeps outputs glitch-free
        st_nxt.arb_req = lif.present; // R22
        st_nxt.arb_level = lif.level; // R1
        case (st_r.st)
            APB_IDLE: begin
                if (psel && !penable) begin
                    st_nxt.st = APB_ACK;
                    st_nxt.pready = 1'b1;
                    st_nxt.pslverr = !mapped;
                    st_nxt.prdata = pwrite ? 32'h0000_0000 : {16'h0000, read_val};
                end
            end
            APB_ACK: begin
                st_nxt.st = APB_IDLE;
                st_nxt.pready = 1'b0;
                st_nxt.pslverr = 1'b0;
                st_nxt.prdata = 32'h0000_0000;
                if (psel && penable && pwrite) begin
                    if (hit_timer) begin
                        st_nxt.timer_ab_c_priority_levels = merge16(
                            st_r.timer_ab_c_priority_levels, pwdata[15:0], pstrb[1:0]); // R23
                    end
                    if (hit_serial) begin
                        st_nxt.serial_timer_a_priority_levels = SERIAL_WR_MASK & merge16(
                            st_r.serial_timer_a_priority_levels, pwdata[15:0],
                            pstrb[1:0]); // R3
                    end
                    if (hit_pwm) begin
                        st_nxt.pwm_converter_priority_levels = merge16(
                            st_r.pwm_converter_priority_levels, pwdata[15:0], pstrb[1:0]);
                    end
                end
            end
            default: begin
                st_nxt.st = APB_IDLE;
                st_nxt.pready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.st <= APB_IDLE;
            st_r.timer_ab_c_priority_levels <= RESET_LEVELS; // R2
            st_r.serial_timer_a_priority_levels <= RESET_LEVELS; // R2
            st_r.pwm_converter_priority_levels <= RESET_LEVELS; // R2
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign arb_req = st_r.arb_req;
    assign arb_level = st_r.arb_level;

    always_comb begin
        nz_vec = '0;
        for (int k = 0; k < NUM_REQ; k++) begin
            nz_vec[k] = (fieldv[2*k +: FIELD_W] != LVL_MASKED);
        end
    end

    sequence s_setup;
        psel && !penable && !pready;
    endsequence

    sequence s_commit;
        psel && penable && pready && pwrite;
    endsequence

    property p_reset_clear;
        @(posedge ref_clk) disable iff (1'b0)
        sys_rst |=> (fieldv == '0) && !pready && (arb_req == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared by reset"); // R2

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        st_r.serial_timer_a_priority_levels[11:10] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved serial bits set"); // R3

    property p_write_lands;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_commit and hit_serial && pstrb == 4'hF) |=>
            st_r.serial_timer_a_priority_levels == ($past(pwdata[15:0]) & SERIAL_WR_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("serial write not stored"); // R23

    property p_read_current;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_setup and !pwrite && hit_pwm) |=>
            pready && prdata == {16'h0000, $past(st_r.pwm_converter_priority_levels)};
    endproperty
    a_read_current: assert property (p_read_current) else $error("read data stale"); // R23

    property p_one_wait;
        @(posedge ref_clk) disable iff (sys_rst)
        s_setup |=> pready ##1 !pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not one cycle after setup");

    property p_unmapped_err;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_setup and !mapped) |=> pready && pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not flagged");

    property p_masked_blocked;
        @(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> (arb_req & ~$past(nz_vec)) == '0;
    endproperty
    a_masked_blocked: assert property (p_masked_blocked) else $error("masked request passed"); // R22

    property p_level_decode;
        @(posedge ref_clk) disable iff (sys_rst)
        arb_req[0] && !$past(sys_rst) |->
            arb_level[1:0] == 2'($past(fieldv[1:0]) - LVL_0);
    endproperty
    a_level_decode: assert property (p_level_decode) else $error("level decode wrong"); // R1

    property p_fault_passes;
        @(posedge ref_clk) disable iff (sys_rst)
        irq_req[15] && nz_vec[15] |=> arb_req[15];
    endproperty
    a_fault_passes: assert property (p_fault_passes) else $error("enabled request dropped"); // R15

    // Per-lane view of the registered arbitration outputs
    logic [NUM_REQ-1:0] lane_idle_bad;
    logic [NUM_REQ-1:0] lane_top_bad;

    always_comb begin
        lane_idle_bad = '0;
        lane_top_bad = '0;
        for (int k = 0; k < NUM_REQ; k++) begin
            lane_idle_bad[k] = !arb_req[k] && (arb_level[2*k +: FIELD_W] != 2'h0);
            lane_top_bad[k] = (arb_level[2*k +: FIELD_W] == 2'h3);
        end
    end

    property p_idle_lane_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        lane_idle_bad == '0;
    endproperty
    a_idle_lane_zero: assert property (p_idle_lane_zero) // R1
        else $error("level shown on idle request");

    property p_top_level_absent;
        @(posedge ref_clk) disable iff (sys_rst)
        lane_top_bad == '0;
    endproperty
    a_top_level_absent: assert property (p_top_level_absent) // R1
        else $error("level above two presented");

    property p_reset_outputs;
        @(posedge ref_clk) disable iff (1'b0)
        sys_rst |=> (arb_level == '0) && (prdata == 32'h0000_0000) && !pslverr;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) // R2
        else $error("outputs not cleared by reset");

    property p_timer_write_lands;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_commit and hit_timer && pstrb[1:0] == 2'h3) |=>
            st_r.timer_ab_c_priority_levels == $past(pwdata[15:0]);
    endproperty
    a_timer_write_lands: assert property (p_timer_write_lands) // R23
        else $error("timer write not stored");

    property p_pwm_write_lands;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_commit and hit_pwm && pstrb[1:0] == 2'h3) |=>
            st_r.pwm_converter_priority_levels == $past(pwdata[15:0]);
    endproperty
    a_pwm_write_lands: assert property (p_pwm_write_lands) // R23
        else $error("pwm write not stored");

    property p_lane_keep;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_commit and hit_timer && !pstrb[1]) |=>
            st_r.timer_ab_c_priority_levels[15:8] == $past(st_r.timer_ab_c_priority_levels[15:8]);
    endproperty
    a_lane_keep: assert property (p_lane_keep) // R23
        else $error("unstrobed lane overwritten");

    property p_unmapped_ignored;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_commit and !mapped) |=>
            $stable(st_r.timer_ab_c_priority_levels)
            && $stable(st_r.serial_timer_a_priority_levels)
            && $stable(st_r.pwm_converter_priority_levels);
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored) // R23
        else $error("unmapped write changed a register");

endmodule

// file: verilog/level_gate.sv
// Per-request masking and level decode.
`timescale 1ns/1ns
module level_gate
    import irq_prio_pkg::*;
#(
    parameter int N = 23
) (
    level_if.gate lif
);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_req
            logic on;
            // Code 00 parks the request; 01..11 map to levels 0..2
            assign on = lif.req[i] && (lif.fields[2*i +: FIELD_W] != LVL_MASKED); // R22
            assign lif.present[i] = on;
            assign lif.level[2*i +: FIELD_W] = on ?
                2'(lif.fields[2*i +: FIELD_W] - LVL_0) : 2'h0; // R1
        end
    endgenerate

endmodule

// file: verilog/level_if.sv
// Carrier between the register file and the request gate.
`timescale 1ns/1ns
interface level_if #(
    parameter int N = 23
);
    logic [2*N-1:0] fields;
    logic [N-1:0] req;
    logic [N-1:0] present;
    logic [2*N-1:0] level;

    modport ctl (output fields, output req, input present, input level);
    modport gate (input fields, input req, output present, output level);
endinterface
